/* verilog/drp_pkg.sv */
//----------------------------------------------------------------------
// Purpose: Shared constants and types for refresh and power-down link
// Assumes: One 20 MHz clock shared by both ends
// Notes:   Times in ns or clocks, cycle counts derived from them
//----------------------------------------------------------------------
package drp_pkg;

   //-------------------------------------------------------------------
   // Clock and timing
   //-------------------------------------------------------------------
   localparam int CLK_NS = 50;
   localparam int T_RFC_NS = 160;
   localparam int T_REFI_NS = 7800;
   localparam int T_CKE_NS = 6;
   localparam int T_XS_NS = 170;
   localparam int T_XP_NS = 24;
   localparam int T_XPDLL_NS = 24;
   localparam int T_CKSRE_NS = 10;
   localparam int T_CKSRX_NS = 10;
   localparam int T_XSDLL_CK = 512;
   localparam int T_CPDED_CK = 1;
   localparam int ODTL_CK = 4;
   localparam int PD_MAX_REFI = 9;

   localparam int TW = 12;
   // Least times round up
   localparam logic [TW-1:0] RFC_CYC = TW'((T_RFC_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TW-1:0] CKE_CYC = TW'((T_CKE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TW-1:0] XS_CYC = TW'((T_XS_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TW-1:0] XP_CYC = TW'((T_XP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TW-1:0] XPDLL_CYC =
      TW'((T_XPDLL_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TW-1:0] CKSRE_CYC =
      TW'((T_CKSRE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TW-1:0] CKSRX_CYC =
      TW'((T_CKSRX_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TW-1:0] XSDLL_CYC = TW'(T_XSDLL_CK);
   localparam logic [TW-1:0] CPDED_CYC = TW'(T_CPDED_CK);
   // ODT low for ODTL plus half a clock, rounded up
   localparam logic [TW-1:0] ODTOFF_CYC = TW'(ODTL_CK + 1);
   // Longest times round down
   localparam logic [TW-1:0] REFI_CYC = TW'(T_REFI_NS / CLK_NS);
   localparam logic [TW-1:0] PD_MAX_CYC =
      TW'((PD_MAX_REFI * T_REFI_NS) / CLK_NS);

   //-------------------------------------------------------------------
   // Refresh debt limits and reset values
   //-------------------------------------------------------------------
   localparam logic signed [4:0] DEBT_MAX = 5'sh08;
   localparam logic signed [4:0] DEBT_MIN = -5'sh08;
   localparam logic [13:0] ROW_RST = 14'h0000;

   //-------------------------------------------------------------------
   // Command encoding {cs_n, ras_n, cas_n, we_n}
   //-------------------------------------------------------------------
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_DES = 4'hf;

   typedef enum logic [2:0] {
      DS_RESET = 3'b000,
      DS_IDLE  = 3'b001,
      DS_REF   = 3'b010,
      DS_SREF  = 3'b011,
      DS_PD    = 3'b100
   } drp_dev_state_type;

   typedef enum logic [3:0] {
      CS_IDLE   = 4'b0000,
      CS_REF    = 4'b0001,
      CS_ODTOFF = 4'b0010,
      CS_SR     = 4'b0011,
      CS_SRCLK  = 4'b0100,
      CS_SRXS   = 4'b0101,
      CS_PD     = 4'b0110,
      CS_PDX    = 4'b0111
   } drp_ctl_state_type;

endpackage : drp_pkg

/* verilog/drp_link_if.sv */
//----------------------------------------------------------------------
// Purpose: Command, clock-enable, ODT and reset wires between the ends
// Assumes: Both ends clocked by the same sys_clk_i
// Notes:   All signals driven by the controller end only
//----------------------------------------------------------------------
`timescale 1ns/1ps
interface drp_link_if;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic odt;
   logic reset_n;

   modport ctrl (
      output cke, cs_n, ras_n, cas_n, we_n, odt, reset_n
   );
   modport dram (
      input cke, cs_n, ras_n, cas_n, we_n, odt, reset_n
   );
endinterface : drp_link_if

/* verilog/drp_dram_end.sv */
//----------------------------------------------------------------------
// Purpose: Memory-side refresh, self-refresh and power-down state
// Assumes: Controller keeps its own timing duties
// Notes:   Internal refresh row counter, DLL and receiver status
//----------------------------------------------------------------------
`timescale 1ns/1ps
module drp_dram_end (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // Link
   drp_link_if.dram link,
   // Mode and bank status
   input wire logic bank_open_i,
   input wire logic dll_mode_en_i,
   input wire logic pd_fast_exit_i,
   // Status
   output drp_pkg::drp_dev_state_type state_o,
   output logic dll_on_o,
   output logic dll_rst_o,
   output logic rcv_on_o,
   output logic apd_o,
   output logic int_ref_o,
   output logic [13:0] ref_row_o
);
   import drp_pkg::*;

   typedef struct packed {
      drp_dev_state_type st;
      logic cke_q;
      logic [TW-1:0] tmr;
      logic [TW-1:0] sr_tmr;
      logic [13:0] row;
      logic dll_on;
      logic dll_rst;
      logic rcv_on;
      logic apd;
      logic int_ref;
   } drp_dev_reg_type;

   drp_dev_reg_type r;
   drp_dev_reg_type next_r;
   logic [3:0] cmd;
   logic is_nop;

   // Command decode
   assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
   assign is_nop = (cmd == CMD_NOP) || link.cs_n;

   //-------------------------------------------------------------------
   // Next state
   //-------------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.int_ref = 1'b0;
      next_r.dll_rst = 1'b0;
      next_r.cke_q = link.cke;
      if (!link.reset_n) begin
         next_r.st = DS_RESET;
         next_r.dll_on = 1'b0;
         next_r.rcv_on = 1'b1;
         next_r.apd = 1'b0;
      end else begin
         case (r.st)
            DS_RESET: begin
               next_r.st = DS_IDLE;
               next_r.dll_on = dll_mode_en_i;
            end
            DS_IDLE: begin
               if (!link.cke && r.cke_q && cmd == CMD_REF) begin
                  next_r.st = DS_SREF;
                  next_r.sr_tmr = '0;
                  next_r.dll_on = 1'b0;
               end else if (!link.cke && r.cke_q && is_nop) begin
                  next_r.st = DS_PD;
                  next_r.apd = bank_open_i;
                  next_r.tmr = CPDED_CYC;
                  if (!bank_open_i && !pd_fast_exit_i) begin
                     next_r.dll_on = 1'b0;
                  end
               end else if (link.cke && cmd == CMD_REF) begin
                  next_r.st = DS_REF;
                  next_r.tmr = RFC_CYC - 12'h001;
                  next_r.row = r.row + 14'h0001;
                  next_r.int_ref = 1'b1;
               end
            end
            DS_REF: begin
               if (r.tmr == '0) begin
                  next_r.st = DS_IDLE;
               end else begin
                  next_r.tmr = r.tmr - 12'h001;
               end
            end
            DS_SREF: begin
               if (link.cke) begin
                  next_r.st = DS_IDLE;
                  next_r.dll_on = dll_mode_en_i;
                  next_r.dll_rst = dll_mode_en_i;
               end else if (r.sr_tmr == '0) begin
                  next_r.int_ref = 1'b1;
                  next_r.row = r.row + 14'h0001;
                  next_r.sr_tmr = REFI_CYC - 12'h001;
               end else begin
                  next_r.sr_tmr = r.sr_tmr - 12'h001;
               end
            end
            DS_PD: begin
               if (r.tmr != '0) begin
                  next_r.tmr = r.tmr - 12'h001;
               end else begin
                  next_r.rcv_on = 1'b0;
               end
               if (link.cke) begin
                  next_r.st = DS_IDLE;
                  next_r.rcv_on = 1'b1;
                  next_r.apd = 1'b0;
                  next_r.dll_on = dll_mode_en_i;
               end
            end
            default: next_r.st = DS_RESET;
         endcase
      end
   end

   //-------------------------------------------------------------------
   // State register
   //-------------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         r <= '{st: DS_RESET, cke_q: 1'b0, tmr: '0, sr_tmr: '0,
                row: ROW_RST, dll_on: 1'b0, dll_rst: 1'b0,
                rcv_on: 1'b1, apd: 1'b0, int_ref: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   // Outputs from the state register
   assign state_o = r.st;
   assign dll_on_o = r.dll_on;
   assign dll_rst_o = r.dll_rst;
   assign rcv_on_o = r.rcv_on;
   assign apd_o = r.apd;
   assign int_ref_o = r.int_ref;
   assign ref_row_o = r.row;

endmodule : drp_dram_end

/* verilog/drp_ctrl_end.sv */
//----------------------------------------------------------------------
// Purpose: Controller-side refresh scheduling, self-refresh, power-down
// Assumes: User closes banks and meets precharge time before idle_i
// Notes:   Drives all link wires; clk_stop_ok_o flags when the memory clock may stop in self-refresh
//----------------------------------------------------------------------
// Contract
// - Refresh is low selects, high write enable
// - Refresh only with all banks precharged
// - Only NOP until refresh cycle ends
// - At most eight refreshes postponed
// - Up to eight refreshes pulled in
// - Clear postponed refreshes before self-refresh
// - Self-refresh entry is refresh with low enable
// - Banks idle, termination off before self-refresh
// - Hold enable low during self-refresh
// - Memory toggles its DLL around self-refresh
// - Stay in self-refresh the minimum pulse
// - Clock stop and restart around self-refresh
// - Exit with NOP, then short/long delays
// - NOP during exit, enable high, ODT off
// - Extra refresh before self-refresh re-entry
// - No power-down during busy operations
// - Memory picks active or precharge power-down
// - NOP through power-down entry delay
// - Slow exit stops DLL in precharge power-down
// - Reset low ends power-down
// - Power-down at least pulse, at most nine intervals
// - Power-down exit with NOP, exit latency
//----------------------------------------------------------------------
`timescale 1ns/1ps
module drp_ctrl_end (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // Link
   drp_link_if.ctrl link,
   // User requests and status
   input wire logic idle_i,
   input wire logic busy_i,
   input wire logic bank_open_i,
   input wire logic pd_fast_exit_i,
   input wire logic odt_i,
   input wire logic ref_req_i,
   input wire logic sr_req_i,
   input wire logic pd_req_i,
   // Controller status
   output drp_pkg::drp_ctl_state_type state_o,
   output logic signed [4:0] debt_o,
   output logic ref_due_o,
   output logic ref_urgent_o,
   output logic ref_issued_o,
   output logic cmd_ok_o,
   output logic dll_ready_o,
   output logic clk_stop_ok_o
);
   import drp_pkg::*;

   typedef struct packed {
      drp_ctl_state_type st;
      logic [TW-1:0] tmr;
      logic [TW-1:0] refi_tmr;
      logic [TW-1:0] pd_tmr;
      logic [TW-1:0] dll_tmr;
      logic signed [4:0] debt;
      logic need_ref;
      logic cke;
      logic [3:0] cmd;
      logic odt;
      logic rst_n;
      logic ref_pulse;
      logic clk_stop_ok;
   } drp_ctl_reg_type;

   drp_ctl_reg_type r;
   drp_ctl_reg_type next_r;
   logic tick;
   logic issue_ref;
   logic in_sr;

   // Larger of two cycle counts, minus one for a down-counter
   function automatic logic [TW-1:0] span(input logic [TW-1:0] a,
                                          input logic [TW-1:0] b);
      span = ((a > b) ? a : b) - 12'h001;
   endfunction : span

   // Average refresh interval tick; no debt while memory self-refreshes
   assign tick = (r.refi_tmr == '0);
   assign in_sr = (r.st == CS_SR) || (r.st == CS_SRCLK) ||
                  (r.st == CS_ODTOFF);

   //-------------------------------------------------------------------
   // Refresh issue decision
   //-------------------------------------------------------------------
   always_comb begin
      issue_ref = 1'b0;
      if (r.st == CS_IDLE && r.rst_n) begin
         if (idle_i && !busy_i && (r.debt > 5'sh00 || r.need_ref ||
             (ref_req_i && r.debt > DEBT_MIN))) begin
            issue_ref = 1'b1;
         end
      end
   end

   //-------------------------------------------------------------------
   // Next state
   //-------------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.rst_n = 1'b1;
      next_r.ref_pulse = 1'b0;
      next_r.refi_tmr = tick ? (REFI_CYC - 12'h001) :
                        (r.refi_tmr - 12'h001);
      if (r.dll_tmr != '0) begin
         next_r.dll_tmr = r.dll_tmr - 12'h001;
      end
      if (tick && !in_sr && !issue_ref && r.debt < DEBT_MAX) begin
         next_r.debt = r.debt + 5'sh01;
      end else if (issue_ref && !(tick && !in_sr) &&
                   r.debt > DEBT_MIN) begin
         next_r.debt = r.debt - 5'sh01;
      end
      next_r.odt = odt_i && (r.dll_tmr == '0) && r.st == CS_IDLE;
      next_r.cmd = CMD_NOP;
      case (r.st)
         CS_IDLE: begin
            next_r.cke = 1'b1;
            if (issue_ref) begin
               next_r.cmd = CMD_REF;
               next_r.st = CS_REF;
               next_r.tmr = RFC_CYC - 12'h001;
               next_r.need_ref = 1'b0;
               next_r.ref_pulse = 1'b1;
            end else if (sr_req_i && idle_i && !busy_i &&
                         r.debt <= 5'sh00 && !r.need_ref &&
                         r.tmr == '0) begin
               next_r.st = CS_ODTOFF;
               next_r.odt = 1'b0;
               next_r.tmr = ODTOFF_CYC - 12'h001;
            end else if (pd_req_i && !busy_i && r.dll_tmr == '0 &&
                         r.debt < DEBT_MAX) begin
               next_r.cke = 1'b0;
               next_r.st = CS_PD;
               next_r.tmr = span(CKE_CYC, CPDED_CYC);
               next_r.pd_tmr = '0;
            end else if (r.tmr != '0) begin
               next_r.tmr = r.tmr - 12'h001;
            end
         end
         CS_REF: begin
            if (r.tmr == '0) begin
               next_r.st = CS_IDLE;
            end else begin
               next_r.tmr = r.tmr - 12'h001;
            end
         end
         CS_ODTOFF: begin
            next_r.odt = 1'b0;
            if (r.tmr == '0) begin
               next_r.cmd = CMD_REF;
               next_r.cke = 1'b0;
               next_r.st = CS_SR;
               next_r.tmr = span(CKE_CYC, CKSRE_CYC);
            end else begin
               next_r.tmr = r.tmr - 12'h001;
            end
         end
         CS_SR: begin
            next_r.cke = 1'b0;
            next_r.cmd = CMD_DES;
            if (r.tmr != '0) begin
               next_r.tmr = r.tmr - 12'h001;
            end else if (!sr_req_i) begin
               next_r.st = CS_SRCLK;
               next_r.clk_stop_ok = 1'b0;
               next_r.tmr = CKSRX_CYC - 12'h001;
            end else begin
               next_r.clk_stop_ok = 1'b1;
            end
         end
         CS_SRCLK: begin
            next_r.cke = 1'b0;
            next_r.cmd = CMD_DES;
            if (r.tmr == '0) begin
               next_r.cke = 1'b1;
               next_r.cmd = CMD_NOP;
               next_r.st = CS_SRXS;
               next_r.tmr = XS_CYC - 12'h001;
               next_r.dll_tmr = XSDLL_CYC - 12'h001;
               next_r.need_ref = 1'b1;
            end else begin
               next_r.tmr = r.tmr - 12'h001;
            end
         end
         CS_SRXS: begin
            // only NOP in short exit interval
            next_r.cke = 1'b1;
            if (r.tmr == '0) begin
               next_r.st = CS_IDLE;
            end else begin
               next_r.tmr = r.tmr - 12'h001;
            end
         end
         CS_PD: begin
            next_r.cke = 1'b0;
            next_r.pd_tmr = r.pd_tmr + 12'h001;
            if (r.tmr != '0) begin
               next_r.tmr = r.tmr - 12'h001;
            // min pulse, nine intervals at most
            end else if (!pd_req_i || r.debt >= DEBT_MAX ||
                         r.pd_tmr >= PD_MAX_CYC - 12'h001) begin
               next_r.cke = 1'b1;
               next_r.st = CS_PDX;
               next_r.tmr = span(XP_CYC, CKE_CYC);
               if (!bank_open_i && !pd_fast_exit_i) begin
                  next_r.dll_tmr = XPDLL_CYC - 12'h001;
               end
            end
         end
         CS_PDX: begin
            next_r.cke = 1'b1;
            if (r.tmr == '0) begin
               next_r.st = CS_IDLE;
            end else begin
               next_r.tmr = r.tmr - 12'h001;
            end
         end
         default: next_r.st = CS_IDLE;
      endcase
   end

   //-------------------------------------------------------------------
   // State register
   //-------------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         r <= '{st: CS_IDLE, tmr: '0, refi_tmr: REFI_CYC - 12'h001,
                pd_tmr: '0, dll_tmr: '0, debt: 5'sh00,
                need_ref: 1'b0, cke: 1'b0, cmd: CMD_DES, odt: 1'b0,
                rst_n: 1'b0, ref_pulse: 1'b0, clk_stop_ok: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   //-------------------------------------------------------------------
   // Link and status outputs
   //-------------------------------------------------------------------
   assign link.cke = r.cke;
   assign link.cs_n = r.cmd[3];
   assign link.ras_n = r.cmd[2];
   assign link.cas_n = r.cmd[1];
   assign link.we_n = r.cmd[0];
   assign link.odt = r.odt;
   assign link.reset_n = r.rst_n;
   assign state_o = r.st;
   assign debt_o = r.debt;
   assign ref_due_o = (r.debt > 5'sh00);
   assign ref_urgent_o = (r.debt >= DEBT_MAX);
   assign ref_issued_o = r.ref_pulse;
   assign cmd_ok_o = (r.st == CS_IDLE);
   assign dll_ready_o = (r.dll_tmr == '0);
   assign clk_stop_ok_o = r.clk_stop_ok;

endmodule : drp_ctrl_end

/* dv/drp_link_sva.sv */
// Purpose: Timing checks on the refresh and power-down link
// Assumes: One clock domain, srst_i synchronous active high
// Notes:   Sees interface wires only
`timescale 1ns/1ps
module drp_link_sva (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // Link wires
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic odt,
   input wire logic reset_n
);
   import drp_pkg::*;
   //---------------
   // Tracking
   //---------------
   logic [3:0] cmd;
   logic nop, sre, prev_cke, in_sr, need_ref;
   logic [11:0] pd_cnt;
   // Command decode
   assign cmd = {cs_n, ras_n, cas_n, we_n};
   assign nop = cs_n || (cmd == CMD_NOP);
   assign sre = prev_cke && !cke && (cmd == CMD_REF);
   // Self-refresh, owed refresh, power-down length
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         prev_cke <= 1'b0;
         in_sr <= 1'b0;
         need_ref <= 1'b0;
         pd_cnt <= 12'h000;
      end else begin
         prev_cke <= cke;
         in_sr <= sre || (in_sr && !cke);
         need_ref <= (in_sr && cke) ||
                     (need_ref && (!cke || cmd != CMD_REF));
         pd_cnt <= (!cke && !in_sr && !sre) ? pd_cnt + 12'h001 : 12'h000;
      end
   end
   //---------------
   // Properties
   //---------------
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   sequence s_nop4;
      nop [*4];
   endsequence
   sequence s_srx;
      in_sr && cke;
   endsequence
   property p_ref_quiet;
      prev_cke && cke && cmd == CMD_REF |=> nop [*3];
   endproperty
   a_ref_quiet: assert property (p_ref_quiet)
      else $error("cmd in rfc");
   property p_sre_odt;
      sre |-> !$past(odt) && !$past(odt, 5);
   endproperty
   a_sre_odt: assert property (p_sre_odt)
      else $error("odt at sre");
   property p_srx;
      s_srx |-> s_nop4 and (!odt [*4]);
   endproperty
   a_srx: assert property (p_srx)
      else $error("cmd in exit");
   property p_extra_ref;
      sre |-> !need_ref;
   endproperty
   a_extra_ref: assert property (p_extra_ref)
      else $error("no extra ref");
   property p_pd_entry;
      prev_cke && !cke && !sre |-> nop ##1 nop;
   endproperty
   a_pd_entry: assert property (p_pd_entry)
      else $error("cmd in pd entry");
   property p_cke_low;
      prev_cke && !cke |=> !cke;
   endproperty
   a_cke_low: assert property (p_cke_low)
      else $error("cke low short");
   property p_cke_high;
      !prev_cke && cke |=> cke;
   endproperty
   a_cke_high: assert property (p_cke_high)
      else $error("cke high short");
   property p_pd_max;
      pd_cnt <= PD_MAX_CYC;
   endproperty
   a_pd_max: assert property (p_pd_max)
      else $error("pd too long");
endmodule : drp_link_sva

/* dv/testbench.sv */
// Purpose: Self-checking bench for both link ends
// Assumes: 20 MHz clock, synchronous active-high reset
// Notes:   Controller reset alone drives the memory into reset
`timescale 1ns/1ps
module testbench;
   import drp_pkg::*;
   //---------------
   // Stimulus, status and instances
   //---------------
   logic sys_clk_i = 1'b0, srst_i = 1'b1, mem_srst = 1'b1, idle = 1'b1;
   logic busy = 1'b0, bank_open = 1'b0, fast = 1'b0, odt_req = 1'b0;
   logic ref_req = 1'b0, sr_req = 1'b0, pd_req = 1'b0, dll_mode = 1'b1;
   drp_dev_state_type d_state;
   drp_ctl_state_type c_state;
   logic dll_rst, cmd_ok, stop_ok;
   logic signed [4:0] debt;
   logic dll_on, rcv_on, apd, int_ref, ref_issued, ref_due, urgent, dll_rdy;
   logic [13:0] row;
   int n_errors = 0, samples_checked = 0, cycles = 0;
   // Clock
   always #25 sys_clk_i = ~sys_clk_i;
   drp_link_if drp_link_if_i ();
   drp_ctrl_end drp_ctrl_end_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
      .link(drp_link_if_i.ctrl), .idle_i(idle), .busy_i(busy),
      .bank_open_i(bank_open), .pd_fast_exit_i(fast), .odt_i(odt_req),
      .ref_req_i(ref_req), .sr_req_i(sr_req), .pd_req_i(pd_req),
      .state_o(c_state), .debt_o(debt), .ref_due_o(ref_due),
      .ref_urgent_o(urgent), .ref_issued_o(ref_issued), .cmd_ok_o(cmd_ok),
      .dll_ready_o(dll_rdy), .clk_stop_ok_o(stop_ok));
   drp_dram_end drp_dram_end_i (.sys_clk_i(sys_clk_i), .srst_i(mem_srst),
      .link(drp_link_if_i.dram), .bank_open_i(bank_open),
      .dll_mode_en_i(dll_mode), .pd_fast_exit_i(fast), .state_o(d_state),
      .dll_on_o(dll_on), .dll_rst_o(dll_rst), .rcv_on_o(rcv_on), .apd_o(apd),
      .int_ref_o(int_ref), .ref_row_o(row));
   drp_link_sva drp_link_sva_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
      .cke(drp_link_if_i.cke), .cs_n(drp_link_if_i.cs_n),
      .ras_n(drp_link_if_i.ras_n), .cas_n(drp_link_if_i.cas_n),
      .we_n(drp_link_if_i.we_n), .odt(drp_link_if_i.odt),
      .reset_n(drp_link_if_i.reset_n));
   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask : tick
   task automatic wait_dev(input drp_dev_state_type s, input int lim);
      for (int i = 0; i < lim && d_state !== s; i++)
         tick(1);
      check(d_state, s);
   endtask : wait_dev
   task automatic give_verdict();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   // Regular refresh advances the internal row
   task automatic t_refresh();
      logic [13:0] r;
      for (int i = 0; i < 200 && ref_issued !== 1'b1; i++)
         tick(1);
      r = row;
      tick(4);
      check(row, r + 14'h0001);
   endtask : t_refresh
   // Postpone to the ceiling, then catch up
   task automatic t_postpone();
      int refs;
      refs = 0;
      idle = 1'b0;
      // Stop at eight owed so no ninth refresh is lost
      for (int i = 0; i < 1500 && urgent !== 1'b1; i++) begin
         tick(1);
         refs += ref_issued;
      end
      check(refs, 0);
      check(debt, DEBT_MAX);
      check(urgent, 1'b1);
      idle = 1'b1;
      for (int i = 0; i < 100 && ref_due !== 1'b0; i++)
         tick(1);
      check(debt, 5'sh00);
   endtask : t_postpone
   // Pull in until the floor
   task automatic t_pullin();
      logic signed [4:0] lo;
      lo = 5'sh00;
      ref_req = 1'b1;
      for (int i = 0; i < 150; i++) begin
         tick(1);
         if (debt < lo)
            lo = debt;
      end
      ref_req = 1'b0;
      check(lo, DEBT_MIN);
   endtask : t_pullin
   // Two self-refresh visits, DLL mode on then off, second straight after
   task automatic t_selfref();
      int hits;
      odt_req = 1'b1;
      for (int k = 0; k < 2; k++) begin
         hits = 0;
         dll_mode = (k == 0);
         sr_req = 1'b1;
         wait_dev(DS_SREF, 100);
         for (int i = 0; i < 10; i++) begin
            tick(1);
            hits += int_ref;
         end
         check(dll_on, 1'b0);
         check(hits > 0, 1'b1);
         check({c_state, cmd_ok, stop_ok}, {CS_SR, 2'b01});
         sr_req = 1'b0;
         wait_dev(DS_IDLE, 50);
         check({dll_on, dll_rst}, {2{dll_mode}});
         check({c_state, cmd_ok, stop_ok}, {CS_SRXS, 2'b00});
      end
      dll_mode = 1'b1;
      odt_req = 1'b0;
      for (int i = 0; i < 700 && dll_rdy !== 1'b1; i++)
         tick(1);
      check(dll_rdy, 1'b1);
   endtask : t_selfref
   // Slow, fast and active power-down
   task automatic t_pd();
      logic [3:0] v;
      for (int k = 0; k < 3; k++) begin
         v = (k == 0) ? 4'h0 : (k == 1) ? 4'h5 : 4'hb;
         bank_open = v[3];
         idle = !v[3];
         fast = v[2];
         pd_req = 1'b1;
         wait_dev(DS_PD, 600);
         tick(3);
         check({apd, dll_on}, v[1:0]);
         check(rcv_on, 1'b0);
         pd_req = 1'b0;
         wait_dev(DS_IDLE, 30);
      end
      bank_open = 1'b0;
      idle = 1'b1;
   endtask : t_pd
   // Held power-down, busy refusal, reset in power-down
   task automatic t_pd_misc();
      int n;
      pd_req = 1'b1;
      wait_dev(DS_PD, 600);
      for (n = 0; n < 1500 && d_state === DS_PD; n++)
         tick(1);
      check(n <= PD_MAX_CYC, 1'b1);
      busy = 1'b1;
      tick(20);
      check(drp_link_if_i.cke, 1'b1);
      busy = 1'b0;
      wait_dev(DS_PD, 600);
      srst_i = 1'b1;
      wait_dev(DS_RESET, 5);
      pd_req = 1'b0;
   endtask : t_pd_misc
   // Cycle limit
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         give_verdict();
      end
   end
   // Main sequence
   initial begin
      tick(6);
      srst_i = 1'b0;
      mem_srst = 1'b0;
      tick(3);
      t_refresh();
      t_postpone();
      t_pullin();
      t_selfref();
      t_pd();
      t_pd_misc();
      give_verdict();
   end
endmodule : testbench
